// *** rtl/ctpg_defs.svh ***
`ifndef CTPG_DEFS_SVH
`define CTPG_DEFS_SVH

// Pixel and index widths
`define CTPG_DATA_W 16
`define CTPG_IDX_W 12
`define CTPG_SEL_W 3

// Buffer word layout: {start of frame, end of line, bypass, pixel data}
`define CTPG_WORD_W 19
`define CTPG_SOF_BIT 18
`define CTPG_EOL_BIT 17
`define CTPG_BYP_BIT 16

// Buffer depth in words
`define CTPG_FIFO_DEPTH 16

// Gradient wrap masks
`define CTPG_MASK_8 12'h0FF
`define CTPG_MASK_10 12'h3FF
`define CTPG_MASK_12 12'hFFF

// Reset values
`define CTPG_CNT_RST 12'h000
`define CTPG_IDX_RST 12'h000

`endif

// *** rtl/ctpg_pkg.sv ***
package ctpg_pkg;

    // Pattern selector codes
    typedef enum logic [2:0] {
        CTPG_PATTERN_SELECT_NONE = 3'h0,
        CTPG_PATTERN_SELECT_FIRST = 3'h1,
        CTPG_PATTERN_SELECT_SECOND = 3'h2,
        CTPG_PATTERN_SELECT_THIRD = 3'h3,
        CTPG_PATTERN_SELECT_FOURTH = 3'h4,
        CTPG_PATTERN_SELECT_FIFTH = 3'h5,
        CTPG_PATTERN_SELECT_SIXTH = 3'h6
    } ctpg_pattern_t;

    // Generator states
    typedef enum logic {
        CTPG_ST_IDLE = 1'b0,
        CTPG_ST_GEN = 1'b1
    } ctpg_state_t;

endpackage : ctpg_pkg

// *** rtl/ctpg_fifo_if.sv ***
`timescale 1ns/1ps
`default_nettype none

// Write and read sides of the pixel buffer
interface ctpg_fifo_if #(parameter int WIDTH = 19);
    logic wrValid;
    logic [WIDTH-1:0] wrData;
    logic wrReady;
    logic wrReadyNxt;
    logic rdValid;
    logic [WIDTH-1:0] rdData;
    logic rdReady;

    modport src (output wrValid, output wrData, input wrReady, input wrReadyNxt,
                 input rdValid, input rdData, output rdReady);
    modport buffer (input wrValid, input wrData, output wrReady, output wrReadyNxt,
                    output rdValid, output rdData, input rdReady);
endinterface : ctpg_fifo_if

`default_nettype wire

// *** rtl/ctpg_fifo.sv ***
`timescale 1ns/1ps
`default_nettype none

module ctpg_fifo #(
    parameter int WIDTH = 19,
    parameter int DEPTH = 16
) (
    input wire logic core_clk,
    input wire logic nrst,
    ctpg_fifo_if.buffer f
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wrPtr_q;
    logic [AW-1:0] rdPtr_q;
    logic [AW:0] count_q;
    logic [AW:0] count_d;
    logic push;
    logic pop;

    // Handshakes; output register refills when empty or drained
    assign push = f.wrValid && f.wrReady;
    assign pop = (count_q != '0) && (!f.rdValid || f.rdReady);
    assign count_d = count_q + (AW+1)'(push) - (AW+1)'(pop);
    assign f.wrReadyNxt = count_d < (AW+1)'(DEPTH);

    // Storage, one word per entry
    always_ff @(posedge core_clk) begin
        if (push) begin
            mem[wrPtr_q] <= f.wrData;
        end
    end

    // Pointers and fill level
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            wrPtr_q <= '0;
            rdPtr_q <= '0;
            count_q <= '0;
            f.wrReady <= 1'b0;
        end else begin
            wrPtr_q <= push ? wrPtr_q + 1'b1 : wrPtr_q;
            rdPtr_q <= pop ? rdPtr_q + 1'b1 : rdPtr_q;
            count_q <= count_d;
            f.wrReady <= f.wrReadyNxt; // Registered; low in reset, otherwise equals count below depth
        end
    end

    // Registered read side
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            f.rdValid <= 1'b0;
            f.rdData <= '0;
        end else if (pop) begin
            f.rdValid <= 1'b1;
            f.rdData <= mem[rdPtr_q];
        end else if (f.rdReady) begin
            f.rdValid <= 1'b0;
        end
    end

    a_no_overflow: assert property (@(posedge core_clk) disable iff (!nrst)
        count_q <= (AW+1)'(DEPTH)) else $error("buffer overflow");

endmodule : ctpg_fifo

`default_nettype wire

// *** rtl/ctpg_top.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "ctpg_defs.svh"

// How it works
// - Selector: off or six patterns replace pixels
// - Patterns made only by internal logic
// - Analog settings never touch pattern values
// - Patterns one,two,three,six bypass digital processing
// - Patterns four,five go through digital processing
// - Pattern one: (column+row) mod 256
// - Pattern two: column+row+counter mod 256
// - Counter steps once per acquisition start
// - Pattern three: column+row+counter mod 4096
// - Pattern four equals pattern two values
// - Pattern five equals pattern three values
// - Ten-bit variant: patterns three,five mod 1024
// - Pattern six: moving colour gradient, colour only
module ctpg_top
    import ctpg_pkg::*;
(
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic [`CTPG_SEL_W-1:0] patternSel,
    input wire logic acqStart,
    input wire logic colourStrap,
    input wire logic tenBitStrap,
    input wire logic [`CTPG_IDX_W-1:0] imgWidth,
    input wire logic [`CTPG_IDX_W-1:0] imgHeight,
    input wire logic sensorValid,
    input wire logic [`CTPG_DATA_W-1:0] sensorData,
    input wire logic sensorSof,
    input wire logic sensorEol,
    output logic sensorReady,
    output logic pixValid,
    output logic [`CTPG_DATA_W-1:0] pixData,
    output logic pixSof,
    output logic pixEol,
    output logic pixBypass,
    input wire logic pixReady,
    output logic genBusy
);

    ctpg_fifo_if #(.WIDTH(`CTPG_WORD_W)) fif ();

    ctpg_state_t state_q;
    ctpg_state_t state_d;
    ctpg_pattern_t frmPat_q;
    logic [`CTPG_IDX_W-1:0] acqCount_q;
    logic [`CTPG_IDX_W-1:0] frmCnt_q;
    logic [`CTPG_IDX_W-1:0] col_q;
    logic [`CTPG_IDX_W-1:0] row_q;
    logic strapDone_q;
    logic colourVar_q;
    logic tenBitVar_q;
    logic sensorReady_q;
    logic genBusy_q;
    logic selValid;
    logic frameGo;
    logic genPush;
    logic lastCol;
    logic lastPix;
    logic [`CTPG_IDX_W-1:0] sumFix;
    logic [`CTPG_IDX_W-1:0] sumMov;
    logic [`CTPG_IDX_W-1:0] mask12;
    logic [`CTPG_DATA_W-1:0] genData;
    logic genBypass;

    // Variant straps caught once after reset release
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            strapDone_q <= 1'b0;
            colourVar_q <= 1'b0;
            tenBitVar_q <= 1'b0;
        end else if (!strapDone_q) begin
            strapDone_q <= 1'b1;
            colourVar_q <= colourStrap;
            tenBitVar_q <= tenBitStrap;
        end
    end

    // Legal selection; sixth pattern exists only on colour parts
    always_comb begin
        selValid = 1'b0;
        if (patternSel >= CTPG_PATTERN_SELECT_FIRST && patternSel <= CTPG_PATTERN_SELECT_FIFTH) begin
            selValid = 1'b1;
        end else if (patternSel == CTPG_PATTERN_SELECT_SIXTH) begin
            selValid = colourVar_q;
        end
    end

    assign frameGo = acqStart && (state_q == CTPG_ST_IDLE) && selValid && strapDone_q;
    assign genPush = (state_q == CTPG_ST_GEN) && fif.wrReady;
    assign lastCol = (col_q == imgWidth - 1'b1) || (imgWidth == '0);
    assign lastPix = lastCol && ((row_q == imgHeight - 1'b1) || (imgHeight == '0));

    // Acquisition counter, one step per started acquisition
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            acqCount_q <= `CTPG_CNT_RST;
        end else if (acqStart) begin
            acqCount_q <= acqCount_q + 1'b1;
        end
    end

    // Counter value frozen for the frame; a start mid-frame must not tear the image
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            frmCnt_q <= `CTPG_CNT_RST;
        end else if (frameGo) begin
            frmCnt_q <= acqCount_q + 1'b1;
        end
    end

    // Frame state: one full raster per acquisition start taken while idle with a legal selection
    always_comb begin
        state_d = state_q;
        case (state_q)
            CTPG_ST_IDLE: begin
                if (frameGo) begin
                    state_d = CTPG_ST_GEN;
                end
            end
            CTPG_ST_GEN: begin
                if (genPush && lastPix) begin
                    state_d = CTPG_ST_IDLE;
                end
            end
            default: begin
                state_d = CTPG_ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            state_q <= CTPG_ST_IDLE;
            frmPat_q <= CTPG_PATTERN_SELECT_NONE;
        end else begin
            state_q <= state_d;
            if (frameGo) begin
                frmPat_q <= ctpg_pattern_t'(patternSel); // Held stable for the frame
            end
        end
    end

    // Raster position, counted from zero at the first pixel
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            col_q <= `CTPG_IDX_RST;
            row_q <= `CTPG_IDX_RST;
        end else if (frameGo) begin
            col_q <= `CTPG_IDX_RST;
            row_q <= `CTPG_IDX_RST;
        end else if (genPush) begin
            col_q <= lastCol ? `CTPG_IDX_RST : col_q + 1'b1;
            row_q <= lastCol ? row_q + 1'b1 : row_q;
        end
    end

    // Gradient sums wrap at the index width
    assign sumFix = col_q + row_q;
    assign sumMov = col_q + row_q + frmCnt_q;
    assign mask12 = tenBitVar_q ? `CTPG_MASK_10 : `CTPG_MASK_12;

    // Pattern value from position and counter only
    always_comb begin
        genData = '0;
        genBypass = 1'b1;
        case (frmPat_q)
            CTPG_PATTERN_SELECT_FIRST: begin
                genData = {4'h0, sumFix & `CTPG_MASK_8};
            end
            CTPG_PATTERN_SELECT_SECOND: begin
                genData = {4'h0, sumMov & `CTPG_MASK_8};
            end
            CTPG_PATTERN_SELECT_THIRD: begin
                genData = {4'h0, sumMov & mask12};
            end
            CTPG_PATTERN_SELECT_FOURTH: begin
                genData = {4'h0, sumMov & `CTPG_MASK_8};
                genBypass = 1'b0;
            end
            CTPG_PATTERN_SELECT_FIFTH: begin
                genData = {4'h0, sumMov & mask12};
                genBypass = 1'b0;
            end
            CTPG_PATTERN_SELECT_SIXTH: begin
                // Chroma alternates U on even, V on odd columns; luma in low byte
                genData[7:0] = sumMov[7:0];
                genData[15:8] = col_q[0] ? (row_q[7:0] + frmCnt_q[7:0]) : (col_q[7:0] + frmCnt_q[7:0]);
            end
            default: begin
                genData = '0;
            end
        endcase
    end

    // Buffer write side: generated raster or camera pixels
    always_comb begin
        if (state_q == CTPG_ST_GEN) begin
            fif.wrValid = 1'b1;
            fif.wrData = {(col_q == '0) && (row_q == '0), lastCol, genBypass, genData};
        end else begin
            fif.wrValid = sensorValid && sensorReady_q;
            fif.wrData = {sensorSof, sensorEol, 1'b0, sensorData};
        end
    end

    // Camera pixels are refused while a pattern frame runs
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            sensorReady_q <= 1'b0;
            genBusy_q <= 1'b0;
        end else begin
            sensorReady_q <= fif.wrReadyNxt && (state_d == CTPG_ST_IDLE);
            genBusy_q <= (state_d == CTPG_ST_GEN);
        end
    end

    ctpg_fifo #(.WIDTH(`CTPG_WORD_W), .DEPTH(`CTPG_FIFO_DEPTH)) u_fifo (
        .core_clk(core_clk),
        .nrst(nrst),
        .f(fif.buffer)
    );

    // Outputs straight from registers
    assign fif.rdReady = pixReady;
    assign pixValid = fif.rdValid;
    assign pixData = fif.rdData[`CTPG_DATA_W-1:0];
    assign pixSof = fif.rdData[`CTPG_SOF_BIT];
    assign pixEol = fif.rdData[`CTPG_EOL_BIT];
    assign pixBypass = fif.rdData[`CTPG_BYP_BIT];
    assign sensorReady = sensorReady_q;
    assign genBusy = genBusy_q;

    // Checks
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!nrst);

    sequence s_frame_go;
        acqStart && (state_q == CTPG_ST_IDLE) && selValid && strapDone_q;
    endsequence

    sequence s_first_pix;
        (state_q == CTPG_ST_GEN) && (col_q == '0) && (row_q == '0);
    endsequence

    sequence s_last_push;
        genPush && lastPix;
    endsequence

    a_frame_start: assert property (s_frame_go |=> s_first_pix)
        else $error("pattern frame did not start at origin");

    a_count_step: assert property (acqStart |=> acqCount_q == $past(acqCount_q) + 1'b1)
        else $error("acquisition counter did not step");

    a_count_hold: assert property (!acqStart |=> $stable(acqCount_q))
        else $error("acquisition counter moved without a start");

    a_sensor_blocked: assert property ((state_q == CTPG_ST_GEN) |-> !sensorReady && !fif.wrData[`CTPG_BYP_BIT] == !genBypass)
        else $error("camera pixels accepted during pattern frame");

    a_pat_one: assert property (genPush && frmPat_q == CTPG_PATTERN_SELECT_FIRST
        |-> fif.wrData[15:0] == {8'h00, 8'(col_q + row_q)})
        else $error("pattern one value wrong");

    a_pat_two: assert property (genPush && (frmPat_q == CTPG_PATTERN_SELECT_SECOND || frmPat_q == CTPG_PATTERN_SELECT_FOURTH)
        |-> fif.wrData[15:0] == {8'h00, 8'(col_q + row_q + frmCnt_q)})
        else $error("eight bit moving value wrong");

    a_pat_three: assert property (genPush && (frmPat_q == CTPG_PATTERN_SELECT_THIRD || frmPat_q == CTPG_PATTERN_SELECT_FIFTH)
        |-> fif.wrData[15:0] == {4'h0, (col_q + row_q + frmCnt_q) & (tenBitVar_q ? `CTPG_MASK_10 : `CTPG_MASK_12)})
        else $error("twelve bit moving value wrong");

    a_bypass_flag: assert property (genPush |-> fif.wrData[`CTPG_BYP_BIT] ==
        !(frmPat_q == CTPG_PATTERN_SELECT_FOURTH || frmPat_q == CTPG_PATTERN_SELECT_FIFTH))
        else $error("bypass flag wrong for pattern");

    a_colour_only: assert property ((state_q == CTPG_ST_GEN) && frmPat_q == CTPG_PATTERN_SELECT_SIXTH |-> colourVar_q)
        else $error("colour pattern on mono part");

    a_raster_step: assert property (genPush && !lastCol |=> col_q == $past(col_q) + 1'b1 && $stable(row_q))
        else $error("column did not advance");

    a_row_step: assert property (genPush && lastCol && !lastPix |=> (col_q == '0) && (row_q == $past(row_q) + 1'b1))
        else $error("row did not advance at line end");

    a_frame_end: assert property (s_last_push |=> (state_q == CTPG_ST_IDLE) && !genBusy)
        else $error("frame did not end after last pixel");

    a_count_frozen: assert property (s_frame_go |=> frmCnt_q == acqCount_q)
        else $error("frame counter not taken at frame start");

    a_count_steady: assert property ((state_q == CTPG_ST_GEN) |=> $stable(frmCnt_q))
        else $error("frame counter moved inside a frame");

    a_pat_hold: assert property ((state_q == CTPG_ST_GEN) |=> $stable(frmPat_q))
        else $error("pattern changed inside a frame");

    a_pat_sixth: assert property (genPush && frmPat_q == CTPG_PATTERN_SELECT_SIXTH
        |-> fif.wrData[7:0] == 8'(col_q + row_q + frmCnt_q) && fif.wrData[`CTPG_BYP_BIT])
        else $error("colour pattern luma wrong");

endmodule : ctpg_top

`default_nettype wire

// *** dv/ctpg_pixel_sink.sv ***
`timescale 1ns/1ps
`default_nettype none

// Downstream pixel path: ready always, every other cycle, or never
module ctpg_pixel_sink (
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic [1:0] sinkMode,
    input wire logic pixValid,
    input wire logic [15:0] pixData,
    output logic pixReady,
    output logic [7:0] holdErrs
);
    logic [15:0] lastData;
    logic stalled;

    // Ready pattern per mode
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            pixReady <= 1'b0;
        end else begin
            case (sinkMode)
                2'h0: pixReady <= 1'b1;
                2'h1: pixReady <= !pixReady;
                default: pixReady <= 1'b0;
            endcase
        end
    end

    // An offered word that was not taken must stay put
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            stalled <= 1'b0;
            lastData <= 16'h0000;
            holdErrs <= 8'h00;
        end else begin
            stalled <= pixValid && !pixReady;
            lastData <= pixData;
            if (stalled && (!pixValid || pixData != lastData)) holdErrs <= holdErrs + 8'h01;
        end
    end
endmodule : ctpg_pixel_sink

`default_nettype wire

// *** dv/tb_camera_test_pattern_generator.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "ctpg_defs.svh"

module tb_camera_test_pattern_generator
    import ctpg_pkg::*;
;
    logic core_clk = 1'b0, nrst = 1'b0, acqStart = 1'b0, colourStrap = 1'b0, tenBitStrap = 1'b0;
    logic [2:0] patternSel = 3'h0;
    logic [11:0] imgWidth = 12'h001, imgHeight = 12'h001, expCnt = 12'h000;
    logic sensorValid = 1'b0, sensorSof = 1'b0, sensorEol = 1'b0, tenMode = 1'b0;
    logic [15:0] sensorData = 16'h0000;
    logic [1:0] sinkMode = 2'h0;
    wire logic sensorReady, pixValid, pixSof, pixEol, pixBypass, pixReady, genBusy;
    wire logic [15:0] pixData;
    wire logic [7:0] holdErrs;
    int mismatches = 0, samples_checked = 0;

    always #50 core_clk = ~core_clk;

    ctpg_top i_dut (.core_clk(core_clk), .nrst(nrst), .patternSel(patternSel), .acqStart(acqStart),
        .colourStrap(colourStrap), .tenBitStrap(tenBitStrap), .imgWidth(imgWidth), .imgHeight(imgHeight),
        .sensorValid(sensorValid), .sensorData(sensorData), .sensorSof(sensorSof), .sensorEol(sensorEol),
        .sensorReady(sensorReady), .pixValid(pixValid), .pixData(pixData), .pixSof(pixSof), .pixEol(pixEol),
        .pixBypass(pixBypass), .pixReady(pixReady), .genBusy(genBusy));
    ctpg_pixel_sink i_sink (.core_clk(core_clk), .nrst(nrst), .sinkMode(sinkMode), .pixValid(pixValid),
        .pixData(pixData), .pixReady(pixReady), .holdErrs(holdErrs));

    task automatic check16(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check16

    task automatic check1(input logic got, input logic exp);
        check16({15'h0000, got}, {15'h0000, exp});
    endtask : check1

    task automatic summarize();
        $display("checked %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : summarize

    // Expected {sof, eol, bypass, data}; chroma only for the colour pattern
    function automatic logic [18:0] expect_word(input ctpg_pattern_t pat, input int n, input int w);
        int c, r;
        logic [11:0] v;
        c = n % w;
        r = n / w;
        v = 12'(c + r) + expCnt;
        case (pat)
            CTPG_PATTERN_SELECT_NONE: return {n == 0, n[1:0] == 2'h3, 1'b0, 16'hA000 + 16'(n)};
            CTPG_PATTERN_SELECT_FIRST: v = 12'(c + r) & `CTPG_MASK_8;
            CTPG_PATTERN_SELECT_SECOND, CTPG_PATTERN_SELECT_FOURTH: v = v & `CTPG_MASK_8;
            CTPG_PATTERN_SELECT_SIXTH: return {n == 0, c == w - 1, 1'b1, 8'(((c % 2 == 0) ? 12'(c) : 12'(r)) + expCnt),
                8'(12'(c + r) + expCnt)};
            default: v = v & (tenMode ? `CTPG_MASK_10 : `CTPG_MASK_12);
        endcase
        return {n == 0, c == w - 1, pat != CTPG_PATTERN_SELECT_FOURTH && pat != CTPG_PATTERN_SELECT_FIFTH, 4'h0, v};
    endfunction : expect_word

    task automatic collect(input ctpg_pattern_t pat, input int total, input int w);
        logic [18:0] e;
        int n, t;
        n = 0;
        t = 0;
        while (n < total && t < 20000) begin
            @(posedge core_clk);
            t++;
            if (pixValid === 1'b1 && pixReady === 1'b1) begin
                e = expect_word(pat, n, w);
                check16(pixData, e[15:0]);
                check1(pixBypass, e[16]);
                check1(pixSof, e[18]);
                check1(pixEol, e[17]);
                n++;
                t = 0;
            end
        end
        check16(16'(n), 16'(total));
    endtask : collect

    task automatic do_reset(input logic colour, input logic ten);
        nrst <= 1'b0;
        colourStrap <= colour;
        tenBitStrap <= ten;
        tenMode = ten;
        repeat (2) @(posedge core_clk);
        nrst <= 1'b1;
        repeat (2) @(posedge core_clk);
        expCnt = 12'h000;
    endtask : do_reset

    task automatic run_frame(input ctpg_pattern_t pat, input int w, input int h, input logic extra);
        patternSel <= pat;
        imgWidth <= 12'(w);
        imgHeight <= 12'(h);
        acqStart <= 1'b1;
        @(posedge core_clk);
        acqStart <= 1'b0;
        expCnt = expCnt + 12'h001;
        @(posedge core_clk);
        check1(genBusy, 1'b1);
        check1(sensorReady, 1'b0);
        acqStart <= extra;
        @(posedge core_clk);
        acqStart <= 1'b0;
        collect(pat, w * h, w);
        expCnt = expCnt + 12'(extra);
        repeat (2) @(posedge core_clk);
        check1(genBusy, 1'b0);
    endtask : run_frame

    // Camera words fill the buffer while the sink stalls, then drain in order
    task automatic test_camera_fill();
        int sent, t;
        sinkMode <= 2'h2;
        sent = 0;
        t = 0;
        sensorValid <= 1'b1;
        sensorData <= 16'hA000;
        sensorSof <= 1'b1;
        while (t < 8) begin
            @(posedge core_clk);
            t++;
            if (sensorReady === 1'b1) begin
                sent++;
                t = 0;
                sensorData <= 16'hA000 + 16'(sent);
                sensorSof <= 1'b0;
                sensorEol <= sent % 4 == 3;
            end
        end
        sensorValid <= 1'b0;
        check1(sent >= `CTPG_FIFO_DEPTH && sent <= `CTPG_FIFO_DEPTH + 1, 1'b1);
        sinkMode <= 2'h0;
        collect(CTPG_PATTERN_SELECT_NONE, sent, 1);
        $display("test camera fill done");
    endtask : test_camera_fill

    task automatic test_gray8();
        sinkMode <= 2'h1;
        run_frame(CTPG_PATTERN_SELECT_FIRST, 260, 2, 1'b0);
        run_frame(CTPG_PATTERN_SELECT_SECOND, 6, 3, 1'b1);
        run_frame(CTPG_PATTERN_SELECT_SECOND, 6, 3, 1'b0);
        run_frame(CTPG_PATTERN_SELECT_FOURTH, 260, 2, 1'b0);
        $display("test gray8 done");
    endtask : test_gray8

    task automatic test_gray12();
        sinkMode <= 2'h0;
        run_frame(CTPG_PATTERN_SELECT_THIRD, 4095, 1, 1'b0);
        sinkMode <= 2'h1;
        run_frame(CTPG_PATTERN_SELECT_FIFTH, 4095, 1, 1'b0);
        patternSel <= CTPG_PATTERN_SELECT_SIXTH;
        acqStart <= 1'b1;
        @(posedge core_clk);
        patternSel <= 3'h7;
        @(posedge core_clk);
        acqStart <= 1'b0;
        expCnt = expCnt + 12'h002;
        repeat (3) @(posedge core_clk);
        check1(genBusy, 1'b0);
        check1(pixValid, 1'b0);
        check16({8'h00, holdErrs}, 16'h0000);
        $display("test gray12 done");
    endtask : test_gray12

    task automatic test_variants();
        do_reset(1'b1, 1'b1);
        sinkMode <= 2'h1;
        run_frame(CTPG_PATTERN_SELECT_THIRD, 1030, 2, 1'b0);
        run_frame(CTPG_PATTERN_SELECT_FIFTH, 1030, 1, 1'b0);
        run_frame(CTPG_PATTERN_SELECT_SIXTH, 260, 2, 1'b0);
        check16({8'h00, holdErrs}, 16'h0000);
        $display("test variants done");
    endtask : test_variants

    // Main sequence
    initial begin
        do_reset(1'b0, 1'b0);
        test_camera_fill();
        test_gray8();
        test_gray12();
        test_variants();
        summarize();
    end

    // Watchdog over the expected run length
    initial begin
        repeat (80000) @(posedge core_clk);
        mismatches++;
        $display("unexpected at %0t: got %h expected %h", $time, 1'b0, 1'b1);
        summarize();
    end
endmodule : tb_camera_test_pattern_generator

`default_nettype wire
